// File: pspr_pkg.sv
// Constants, carrier types and helper functions for the pulse output, phase and sign register bank.
package pspr_pkg;

  localparam int PWR_W = 24;
  localparam int SUM_W = PWR_W + 2;
  localparam int PHCAL_W = 10;

  // Register addresses on the host port.
  localparam logic [15:0] ADDR_COMP_MODE = 16'he60e;
  localparam logic [15:0] ADDR_PULSE_CFG = 16'he610;
  localparam logic [15:0] ADDR_PHCAL_A = 16'he614;
  localparam logic [15:0] ADDR_PHCAL_B = 16'he615;
  localparam logic [15:0] ADDR_PHCAL_C = 16'he616;
  localparam logic [15:0] ADDR_SIGN = 16'he617;
  localparam logic [15:0] ADDR_ACCUM_MODE = 16'he701;

  // Pulse configuration layout.
  localparam int PCFG_SEL1_LSB = 0;
  localparam int PCFG_SEL2_LSB = 3;
  localparam int PCFG_SEL3_LSB = 6;
  localparam int PCFG_DIS1_BIT = 9;
  localparam int PCFG_DIS2_BIT = 10;
  localparam int PCFG_DIS3_BIT = 11;
  localparam int PCFG_LATCH1_BIT = 12;
  localparam int PCFG_LATCH2_BIT = 13;
  localparam int PCFG_LATCH3_BIT = 14;
  localparam logic [15:0] PCFG_RST = 16'h0e88;
  localparam logic [15:0] PCFG_STORE_MASK = 16'h7fff;

  // Computation mode: three phase-select fields of three bits each.
  localparam int COMP_TERM1_LSB = 0;
  localparam int COMP_TERM2_LSB = 3;
  localparam int COMP_TERM3_LSB = 6;
  localparam logic [15:0] COMP_RST = 16'h01ff;
  localparam logic [15:0] COMP_STORE_MASK = 16'h01ff;

  // Accumulation mode sign source bits.
  localparam int ACC_ACTIVE_SRC_BIT = 6;
  localparam int ACC_REACTIVE_SRC_BIT = 7;
  localparam logic [15:0] ACC_RST = 16'h0000;

  // Phase calibration aliasing limits.
  localparam logic [PHCAL_W-1:0] PHCAL_RST = 10'h000;
  localparam logic [PHCAL_W-1:0] PHCAL_ALIAS1_LO = 10'h180;
  localparam logic [PHCAL_W-1:0] PHCAL_ALIAS1_HI = 10'h1ff;
  localparam logic [PHCAL_W-1:0] PHCAL_ALIAS1_SHIFT = 10'h080;
  localparam logic [PHCAL_W-1:0] PHCAL_ALIAS2_LO = 10'h240;
  localparam logic [PHCAL_W-1:0] PHCAL_ALIAS2_BASE = 10'h180;

  // Sign status layout.
  localparam int SIGN_ACT_LSB = 0;
  localparam int SIGN_SUM1_BIT = 3;
  localparam int SIGN_REACT_LSB = 4;
  localparam int SIGN_SUM2_BIT = 7;
  localparam int SIGN_SUM3_BIT = 8;
  localparam logic [8:0] SIGN_RST = 9'h000;

  typedef enum logic [2:0] {
    PT_TOTAL_ACTIVE = 3'h0,
    PT_TOTAL_REACTIVE = 3'h1,
    PT_APPARENT = 3'h2,
    PT_FUND_ACTIVE = 3'h3,
    PT_FUND_REACTIVE = 3'h4
  } pspr_ptype_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wr_data;
    logic wr_en;
    logic rd_en;
  } pspr_bus_req_type;

  typedef logic signed [PWR_W-1:0] pspr_pwr_type;

  // Per-phase powers, index 0 is phase A.
  typedef struct packed {
    pspr_pwr_type [2:0] total_active;
    pspr_pwr_type [2:0] fund_active;
    pspr_pwr_type [2:0] total_reactive;
    pspr_pwr_type [2:0] fund_reactive;
    pspr_pwr_type [2:0] apparent;
  } pspr_power_type;

  // Effective compensation after folding the out-of-range codes.
  function automatic logic [PHCAL_W-1:0] phase_comp_eff(input logic [PHCAL_W-1:0] v);
    logic [PHCAL_W-1:0] off;
    off = v - PHCAL_ALIAS2_LO;
    if (v >= PHCAL_ALIAS2_LO) begin
      // Fold into 384..511, which itself behaves as 256..383.
      phase_comp_eff = PHCAL_ALIAS2_BASE + {3'h0, off[6:0]} - PHCAL_ALIAS1_SHIFT;
    end else if (v >= PHCAL_ALIAS1_LO && v <= PHCAL_ALIAS1_HI) begin
      phase_comp_eff = v - PHCAL_ALIAS1_SHIFT;
    end else begin
      phase_comp_eff = v;
    end
  endfunction

  // Sign of the sum of selected phase powers of the selected type.
  function automatic logic path_sum_negative(input logic [2:0] sel, input logic [2:0] terms,
                                             input pspr_power_type pwr, input logic has_reactive);
    logic signed [SUM_W-1:0] acc;
    logic signed [PWR_W-1:0] term;
    logic valid;
    acc = '0;
    term = '0;
    valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      case (sel)
        PT_TOTAL_ACTIVE: term = pwr.total_active[i];
        PT_TOTAL_REACTIVE: term = has_reactive ? pwr.total_reactive[i] : '0;
        PT_APPARENT: term = pwr.apparent[i];
        PT_FUND_ACTIVE: term = pwr.fund_active[i];
        PT_FUND_REACTIVE: term = has_reactive ? pwr.fund_reactive[i] : '0;
        default: begin
          term = '0;
          valid = 1'b0;
        end
      endcase
      if (terms[i]) begin
        acc = acc + SUM_W'(term);
      end
    end
    path_sum_negative = valid & acc[SUM_W-1];
  endfunction

endpackage

// File: pspr_regs.sv
// Pulse output configuration, phase calibration and power sign register bank.
`timescale 1ns/100ps
module pspr_regs import pspr_pkg::*; #(
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire pspr_bus_req_type i_bus,
  output logic [15:0] o_rd_data,
  input wire pspr_power_type i_power,
  input wire logic [2:0] i_pulse_raw,
  output logic [2:0] o_pulse_out,
  output logic [2:0] o_energy_latch,
  output logic [2:0][PHCAL_W-1:0] o_phase_comp_value,
  output logic [2:0][2:0] o_path_power_type,
  output logic [2:0][2:0] o_path_phase_select,
  output logic [15:0] o_accumulation_mode
);

  // Refuse a width that cannot even hold a sign.
  if (PWR_W < 2) begin : g_width_check
    $error("pspr_regs: power width too small");
  end

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [15:0] pulse_cfg_ff;
  logic [15:0] comp_mode_ff;
  logic [15:0] accum_mode_ff;
  logic [2:0][PHCAL_W-1:0] phcal_ff;
  logic [2:0][PHCAL_W-1:0] comp_eff_ff;
  logic [8:0] sign_ff;
  logic [8:0] nxt_sign;
  logic [2:0] pulse_prev_ff;
  logic [2:0] pulse_out_ff;
  logic [2:0] latch_ff;
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;
  logic [2:0] pulse_rise;
  logic [2:0] dis_bits;
  logic [2:0] latch_bits;
  logic wr_pcfg;
  logic wr_comp;
  logic wr_acc;
  logic [2:0] wr_phcal;

  // Reset is applied at once but released only after two clean edges.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Write decode; the sign status address has no write decode at all.
  assign wr_pcfg = i_bus.wr_en && (i_bus.addr == ADDR_PULSE_CFG);
  assign wr_comp = i_bus.wr_en && (i_bus.addr == ADDR_COMP_MODE);
  assign wr_acc = i_bus.wr_en && (i_bus.addr == ADDR_ACCUM_MODE);
  assign wr_phcal[0] = i_bus.wr_en && (i_bus.addr == ADDR_PHCAL_A);
  assign wr_phcal[1] = i_bus.wr_en && (i_bus.addr == ADDR_PHCAL_B);
  assign wr_phcal[2] = i_bus.wr_en && (i_bus.addr == ADDR_PHCAL_C);

  // Pulse configuration; bit 15 is never stored so it cannot steer anything.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pulse_cfg_ff <= PCFG_RST;
    end else if (wr_pcfg) begin
      pulse_cfg_ff <= i_bus.wr_data & PCFG_STORE_MASK;
    end
  end

  // Phase selection for the three pulse paths.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      comp_mode_ff <= COMP_RST;
    end else if (wr_comp) begin
      comp_mode_ff <= i_bus.wr_data & COMP_STORE_MASK;
    end
  end

  // Accumulation mode is kept whole; only the sign source bits are used here.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      accum_mode_ff <= ACC_RST;
    end else if (wr_acc) begin
      accum_mode_ff <= i_bus.wr_data;
    end
  end

  // Calibration words keep ten bits; the reserved upper bits are dropped on write.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      phcal_ff <= {3{PHCAL_RST}};
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_phcal[p]) begin
          phcal_ff[p] <= i_bus.wr_data[PHCAL_W-1:0];
        end
      end
    end
  end

  // Values outside the legal ranges are folded, not refused, so a bad write still compensates.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      comp_eff_ff <= {3{PHCAL_RST}};
    end else begin
      for (int p = 0; p < 3; p++) begin
        comp_eff_ff[p] <= phase_comp_eff(phcal_ff[p]);
      end
    end
  end

  // Sign status is computed from the power results every cycle.
  always_comb begin
    nxt_sign = SIGN_RST;
    for (int p = 0; p < 3; p++) begin
      nxt_sign[SIGN_ACT_LSB + p] = accum_mode_ff[ACC_ACTIVE_SRC_BIT] ?
        i_power.fund_active[p][PWR_W-1] : i_power.total_active[p][PWR_W-1];
      nxt_sign[SIGN_REACT_LSB + p] = HAS_REACTIVE && (accum_mode_ff[ACC_REACTIVE_SRC_BIT] ?
        i_power.fund_reactive[p][PWR_W-1] : i_power.total_reactive[p][PWR_W-1]);
    end
    nxt_sign[SIGN_SUM1_BIT] = path_sum_negative(pulse_cfg_ff[PCFG_SEL1_LSB +: 3],
      comp_mode_ff[COMP_TERM1_LSB +: 3], i_power, HAS_REACTIVE);
    nxt_sign[SIGN_SUM2_BIT] = path_sum_negative(pulse_cfg_ff[PCFG_SEL2_LSB +: 3],
      comp_mode_ff[COMP_TERM2_LSB +: 3], i_power, HAS_REACTIVE);
    nxt_sign[SIGN_SUM3_BIT] = path_sum_negative(pulse_cfg_ff[PCFG_SEL3_LSB +: 3],
      comp_mode_ff[COMP_TERM3_LSB +: 3], i_power, HAS_REACTIVE);
  end

  // Only hardware loads the sign flags; host writes never reach them.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sign_ff <= SIGN_RST;
    end else begin
      sign_ff <= nxt_sign;
    end
  end

  // Converter pulses are edge detected so a long pulse latches energy only once.
  assign dis_bits = {pulse_cfg_ff[PCFG_DIS3_BIT], pulse_cfg_ff[PCFG_DIS2_BIT], pulse_cfg_ff[PCFG_DIS1_BIT]};
  assign latch_bits = {pulse_cfg_ff[PCFG_LATCH3_BIT], pulse_cfg_ff[PCFG_LATCH2_BIT],
                       pulse_cfg_ff[PCFG_LATCH1_BIT]};
  assign pulse_rise = i_pulse_raw & ~pulse_prev_ff;

  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pulse_prev_ff <= 3'h0;
    end else begin
      pulse_prev_ff <= i_pulse_raw;
    end
  end

  // Disabling masks the pin only; the converter and its latch event keep running.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pulse_out_ff <= 3'h0;
    end else begin
      pulse_out_ff <= i_pulse_raw & ~dis_bits;
    end
  end

  // One-cycle latch strobe per enabled pulse, whether or not its pin is disabled.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      latch_ff <= 3'h0;
    end else begin
      latch_ff <= pulse_rise & latch_bits;
    end
  end

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb begin
    nxt_rd_data = 16'h0000;
    if (i_bus.rd_en) begin
      case (i_bus.addr)
        ADDR_PULSE_CFG: nxt_rd_data = pulse_cfg_ff;
        ADDR_COMP_MODE: nxt_rd_data = comp_mode_ff;
        ADDR_ACCUM_MODE: nxt_rd_data = accum_mode_ff;
        ADDR_PHCAL_A: nxt_rd_data = {6'h00, phcal_ff[0]};
        ADDR_PHCAL_B: nxt_rd_data = {6'h00, phcal_ff[1]};
        ADDR_PHCAL_C: nxt_rd_data = {6'h00, phcal_ff[2]};
        ADDR_SIGN: nxt_rd_data = {7'h00, sign_ff};
        default: nxt_rd_data = 16'h0000;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_pulse_out = pulse_out_ff;
  assign o_energy_latch = latch_ff;
  assign o_phase_comp_value = comp_eff_ff;
  assign o_path_power_type = {pulse_cfg_ff[PCFG_SEL3_LSB +: 3], pulse_cfg_ff[PCFG_SEL2_LSB +: 3],
                              pulse_cfg_ff[PCFG_SEL1_LSB +: 3]};
  assign o_path_phase_select = {comp_mode_ff[COMP_TERM3_LSB +: 3], comp_mode_ff[COMP_TERM2_LSB +: 3],
                                comp_mode_ff[COMP_TERM1_LSB +: 3]};
  assign o_accumulation_mode = accum_mode_ff;

endmodule

// File: pspr_regs_chk.sv
// Concurrent checks on the ports of the pulse output, phase and sign register bank.
`timescale 1ns/100ps
module pspr_regs_chk import pspr_pkg::*; #(
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire pspr_bus_req_type i_bus,
  input wire logic [15:0] o_rd_data,
  input wire pspr_power_type i_power,
  input wire logic [2:0] i_pulse_raw,
  input wire logic [2:0] o_pulse_out,
  input wire logic [2:0] o_energy_latch,
  input wire logic [2:0][PHCAL_W-1:0] o_phase_comp_value,
  input wire logic [2:0][2:0] o_path_power_type,
  input wire logic [2:0][2:0] o_path_phase_select,
  input wire logic [15:0] o_accumulation_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  // A folded code never lands in the two aliased bands.
  function automatic bit fold_ok(input logic [PHCAL_W-1:0] v);
    return v < 10'h180 || (v >= 10'h200 && v < 10'h240);
  endfunction

  // Pins, latch strobes and read data are tied to their causes one cycle earlier.
  pulse_mask_a: assert property ((o_pulse_out & ~$past(i_pulse_raw)) == 3'h0)
    else $error("pulse pin high without a converter pulse");
  latch_edge_a: assert property ((o_energy_latch & ~($past(i_pulse_raw) & ~$past(i_pulse_raw, 2))) == 3'h0)
    else $error("energy latch without a rising converter pulse");
  latch_single_a: assert property (o_energy_latch != 3'h0 |=> (o_energy_latch & $past(o_energy_latch)) == 3'h0)
    else $error("energy latch strobe longer than one cycle");
  read_idle_a: assert property (!$past(i_bus.rd_en) |-> o_rd_data == 16'h0000)
    else $error("read data present without a read");
  sign_rsvd_a: assert property ($past(i_bus.rd_en && i_bus.addr == ADDR_SIGN) |-> o_rd_data[15:9] == 7'h00)
    else $error("sign status reserved bits not zero");
  react_off_a: assert property ($past(i_bus.rd_en && i_bus.addr == ADDR_SIGN) && !HAS_REACTIVE |-> o_rd_data[6:4] == 3'h0)
    else $error("reactive sign bits set without reactive measurement");
  cfg_rsvd_a: assert property ($past(i_bus.rd_en && i_bus.addr == ADDR_PULSE_CFG) |-> !o_rd_data[15])
    else $error("pulse config reserved bit not zero");
  cal_rsvd_a: assert property ($past(i_bus.rd_en && i_bus.addr inside {[ADDR_PHCAL_A:ADDR_PHCAL_C]}) |-> o_rd_data[15:10] == 6'h00)
    else $error("calibration reserved bits not zero");
  comp_fold_a: assert property (fold_ok(o_phase_comp_value[0]) && fold_ok(o_phase_comp_value[1]) && fold_ok(o_phase_comp_value[2]))
    else $error("effective calibration inside an aliased band");

  // Main scenarios reached by the bench.
  latch_seen_c: cover property (o_energy_latch != 3'h0);
  pulse_seen_c: cover property (o_pulse_out != 3'h0);
  sign_read_c: cover property ($past(i_bus.rd_en && i_bus.addr == ADDR_SIGN) && o_rd_data != 16'h0000);
endmodule

bind pspr_regs pspr_regs_chk #(.HAS_REACTIVE(HAS_REACTIVE)) pspr_regs_chk_inst (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_bus(i_bus), .o_rd_data(o_rd_data), .i_power(i_power),
  .i_pulse_raw(i_pulse_raw), .o_pulse_out(o_pulse_out), .o_energy_latch(o_energy_latch),
  .o_phase_comp_value(o_phase_comp_value), .o_path_power_type(o_path_power_type),
  .o_path_phase_select(o_path_phase_select), .o_accumulation_mode(o_accumulation_mode));

// File: tb_pspr_regs.sv
// Self-checking bench for the pulse output, phase and sign register bank.
`timescale 1ns/100ps
module tb_pspr_regs import pspr_pkg::*; ;
  logic i_sys_clk;
  logic i_reset_n;
  pspr_bus_req_type bus;
  pspr_power_type pwr;
  logic [15:0] rd_data;
  logic [15:0] rd_data_nr;
  logic [15:0] accm;
  logic [2:0] raw, pout, latch;
  logic [2:0][PHCAL_W-1:0] comp;
  logic [2:0][2:0] ptype, psel;
  int n_errors = 0;
  int check_count = 0;
  // Codes 0x17f, 0x200 and 0x23f are the legal edges; the rest probe the aliased bands.
  logic [9:0] cal_in [7] = '{10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f, 10'h240, 10'h3ff};
  logic [9:0] cal_exp [7] = '{10'h17f, 10'h100, 10'h17f, 10'h200, 10'h23f, 10'h100, 10'h13f};

  pspr_regs pspr_regs_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rd_data(rd_data),
    .i_power(pwr), .i_pulse_raw(raw), .o_pulse_out(pout), .o_energy_latch(latch), .o_phase_comp_value(comp),
    .o_path_power_type(ptype), .o_path_phase_select(psel), .o_accumulation_mode(accm));

  // A second copy without reactive measurement shares all inputs; only its read data are watched.
  pspr_regs #(.HAS_REACTIVE(1'b0)) pspr_regs_noreact_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_bus(bus), .o_rd_data(rd_data_nr), .i_power(pwr), .i_pulse_raw(raw), .o_pulse_out(), .o_energy_latch(),
    .o_phase_comp_value(), .o_path_power_type(), .o_path_phase_select(), .o_accumulation_mode());

  // Free-running 40 MHz clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle strobes; read data is taken in the single cycle after the read strobe.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
    @(posedge i_sys_clk);
    bus.wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wr_data: 16'h0000, wr_en: 1'b0, rd_en: 1'b1};
    @(posedge i_sys_clk);
    bus.rd_en <= 1'b0;
    #1;
    check(name, exp, rd_data);
  endtask

  // Raise the converter outputs once and look at pins and latch strobes.
  task automatic pulse(input logic [2:0] v, input logic [2:0] eout, input logic [2:0] elat);
    @(posedge i_sys_clk);
    raw <= v;
    @(posedge i_sys_clk);
    #1;
    check("pulse_out", 16'(eout), 16'(pout));
    check("energy_latch", 16'(elat), 16'(latch));
    @(posedge i_sys_clk);
    raw <= 3'h0;
    #1;
    check("latch_end", 16'h0000, 16'(latch));
  endtask

  // Watchdog against a hung run.
  initial begin
    #(25 * 20000);
    n_errors++;
    $display("ERROR watchdog expected end seen timeout");
    finish_test();
  end

  // Main sequence.
  initial begin
    i_reset_n = 1'b0;
    bus = '0;
    pwr = '0;
    raw = 3'h0;
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(ADDR_PULSE_CFG, 16'h0e88, "pulse_cfg");
    rd(ADDR_PHCAL_B, 16'h0000, "cal_b");
    rd(ADDR_SIGN, 16'h0000, "sign");
    rd(16'he611, 16'h0000, "unmapped");
    $display("Test reset values done");
    pulse(3'h7, 3'h0, 3'h0);
    wr(ADDR_PULSE_CFG, 16'hf088);
    rd(ADDR_PULSE_CFG, 16'h7088, "pulse_cfg_wr");
    for (int n = 0; n < 3; n++) begin
      pulse(3'h1 << n, 3'h1 << n, 3'h1 << n);
    end
    wr(ADDR_PULSE_CFG, 16'h7e88);
    pulse(3'h5, 3'h0, 3'h5);
    check("path_type", 16'h0088, 16'(ptype));
    wr(ADDR_PULSE_CFG, 16'h0088);
    pulse(3'h7, 3'h7, 3'h0);
    $display("Test pulse outputs done");
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_PHCAL_A + 16'(i % 3), {6'h3f, cal_in[i]});
      repeat (2) @(posedge i_sys_clk);
      #1;
      check("comp_value", 16'(cal_exp[i]), 16'(comp[i % 3]));
      rd(ADDR_PHCAL_A + 16'(i % 3), 16'(cal_in[i]), "cal_rd");
    end
    $display("Test calibration done");
    @(posedge i_sys_clk);
    pwr.total_active <= {24'h000000, 24'h000003, 24'hfffffb};
    pwr.total_reactive <= {24'hfffffe, 24'hffffff, 24'h000001};
    pwr.apparent <= {3{24'h000001}};
    pwr.fund_active <= {24'h000001, 24'hffffff, 24'h000001};
    pwr.fund_reactive <= {24'h000001, 24'h000001, 24'hffffff};
    wr(ADDR_SIGN, 16'hffff);
    rd(ADDR_SIGN, 16'h00e9, "sign_total");
    // Without reactive measurement the reactive flags and the reactive path sum stay low.
    check("sign_no_reactive", 16'h0009, rd_data_nr);
    wr(ADDR_ACCUM_MODE, 16'h00c0);
    // The register updates on the edge the task returns on, so look just after it.
    #1;
    check("accum_mode", 16'h00c0, accm);
    rd(ADDR_SIGN, 16'h009a, "sign_fund");
    wr(ADDR_COMP_MODE, 16'h01fa);
    #1;
    check("phase_sel", 16'h01fa, 16'(psel));
    rd(ADDR_SIGN, 16'h0092, "sign_path1_b");
    // Fundamental active, reserved and fundamental reactive types on paths 1, 2 and 3.
    wr(ADDR_PULSE_CFG, 16'h012b);
    wr(ADDR_COMP_MODE, 16'h007a);
    rd(ADDR_SIGN, 16'h011a, "sign_path_modes");
    $display("Test sign status done");
    finish_test();
  end
endmodule
